// file: dv/acs_core_model.sv
`timescale 1ns/1ps
module acs_core_model (
  input  wire        pclk,
  input  wire  [3:0] conv_channel,
  input  wire        conv_start,
  output logic [9:0] conv_result,
  output logic       conv_done
);
  logic [2:0] cnt_r = 3'h0;
  logic [3:0] ch_r  = 4'h0;
  always @(posedge pclk)
  begin
    cnt_r <= conv_start ? 3'h4 : cnt_r - 3'(cnt_r != 3'h0);
    if (conv_start)
      ch_r <= conv_channel;
  end
  // Inverted when idle, so a stale sample never matches
  assign conv_done   = cnt_r == 3'h1;
  assign conv_result = conv_done ? {6'h25, ch_r} : ~{6'h25, ch_r};
endmodule

// file: dv/acs_sequencer_sva.sv
`timescale 1ns/1ps
module acs_sequencer_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        low_power_mode,
  input wire [3:0]  conv_channel,
  input wire        conv_start,
  input wire        analog_power_enable,
  input wire        seq_busy
);
  logic [7:0] ctl_r;
  wire        acc = psel && penable;
  wire        wr  = acc && pwrite && paddr == 16'h1030;
  // Shadow control word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl_r <= 8'h00;
    else if (wr)
      ctl_r <= pwdata[7:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Starts launched under the old word at a write edge are skipped
  sequence s_st; conv_start && !$past(wr); endsequence
  property p_sch; s_st |-> ctl_r[4] || conv_channel == ctl_r[3:0]; endproperty
  a_sch: assert property (p_sch) else $error("channel");
  property p_grp; s_st |-> !ctl_r[4] || ctl_r[6] || conv_channel[3:2] == ctl_r[3:2]; endproperty
  a_grp: assert property (p_grp) else $error("group");
  property p_go; wr && analog_power_enable |=> seq_busy; endproperty
  a_go: assert property (p_go) else $error("restart");
  property p_pwr; conv_start |-> $past(analog_power_enable); endproperty
  a_pwr: assert property (p_pwr) else $error("unpowered");
  property p_lpm; conv_start |-> !$past(low_power_mode); endproperty
  a_lpm: assert property (p_lpm) else $error("low power");
  property p_off; $fell(analog_power_enable) |-> ##[0:2] !seq_busy; endproperty
  a_off: assert property (p_off) else $error("abort");
  property p_res; acc && !pwrite && paddr >= 16'h1040 |-> prdata[5:0] == 6'h00; endproperty
  a_res: assert property (p_res) else $error("low bits");
  property p_pls; conv_start |=> !conv_start; endproperty
  a_pls: assert property (p_pls) else $error("pulse");
  c_st: cover property (s_st);
  c_go: cover property (wr ##1 seq_busy);
  c_lpm: cover property (low_power_mode && seq_busy);
endmodule
bind acs_sequencer acs_sequencer_chk u_chk (.*);

// file: dv/acs_sequencer_tb.sv
`timescale 1ns/1ps
module acs_sequencer_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        low_power_mode = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, q;
  wire  [31:0] prdata;
  wire  [9:0]  conv_result;
  wire  [3:0]  conv_channel;
  wire         pready, pslverr, conv_start, conv_done, seq_busy, sample_quiet_phase;
  wire         analog_power_enable, conversion_clock_select, stop_exit_delay_enable;
  int          n_fail = 0, tests_run = 0;
  logic [7:0]  modes [8] = '{8'h05, 8'h42, 8'h17, 8'h57, 8'h25, 8'h33, 8'h62, 8'h77};
  acs_sequencer #(.CONV_CYC(4)) dut (.*);
  acs_core_model u_core (.*);
  initial forever #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("TB: checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Setup, access, hold until pready
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Sample while the access stands, then let the ending edge pass
    do
      @(negedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One mode: start, stall in low power, wait flag, check slots
  task automatic run(input logic [7:0] c);
    int         i;
    logic [3:0] e;
    apb(1'b1, 16'h1030, {24'h0, c});
    low_power_mode <= 1'b1;
    apb(1'b0, 16'h1030, 32'h0);
    chk(q, {25'h0, c[6:0]});
    low_power_mode <= 1'b0;
    i = 0;
    do
    begin
      apb(1'b0, 16'h1030, 32'h0);
      i++;
    end
    while (q[7] !== 1'b1 && i < 100);
    chk(q, {24'h0, 1'b1, c[6:0]});
    repeat (20) @(negedge pclk);
    chk(seq_busy, c[5]);
    for (i = c[6] ? 1 : 5; i <= 8; i++)
    begin
      e = !c[4] ? c[3:0] : c[6] ? 4'(i - 1) : {c[3:2], 2'(i - 5)};
      apb(1'b0, 16'(16'h103C + 4 * i), 32'h0);
      chk(q, {16'h0, 6'h25, e, 6'h00});
    end
    $display("TB: mode %h done", c);
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 16'h1034, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, 16'h1034, 32'h7);
    @(negedge pclk);
    chk({analog_power_enable, conversion_clock_select, stop_exit_delay_enable}, 3'h7);
    apb(1'b1, 16'h1034, 32'h1);
    // settle waits shortened: model core settles at once
    repeat (2) @(posedge pclk);
    foreach (modes[k]) run(modes[k]);
    apb(1'b1, 16'h1034, 32'h0);
    repeat (3) @(negedge pclk);
    chk(seq_busy, 1'b0);
    apb(1'b0, 16'h1100, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, 16'h1034, 32'h3);
    run(8'h05);
    end_of_test();
  end
  // Hang guard
  initial
  begin
    #100us;
    n_fail++;
    end_of_test();
  end
endmodule

// file: src/acs_defs.vh
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH
// Register byte addresses
`define ACS_CTL_ADDR      16'h1030
`define ACS_OPT_ADDR      16'h1034
`define ACS_RES_BASE      16'h1040
`define ACS_RES_LAST      16'h105C
// Control/status field positions
`define ACS_CCF_BIT       7
`define ACS_EIGHT_CONVERSION_SELECT_BIT     6
`define ACS_SCAN_BIT      5
`define ACS_MULTI_CHANNEL_SELECT_BIT      4
// Option field positions
`define ACS_PU_BIT        0
`define ACS_CONVERSION_CLOCK_SELECT_BIT      1
`define ACS_DLY_BIT       2
// Reset values (documented reset is undefined; zero chosen)
`define ACS_CTL_RST       8'h00
`define ACS_OPT_RST       8'h00
// Cycles per conversion on the bus clock: 144 per group of four
`define ACS_GROUP_CYC     144
`define ACS_CONV_CYC      (`ACS_GROUP_CYC / 4)
`endif

// file: src/acs_sequencer.v
// Summary of operation
// - Single channel repeats the selected input
// - Single four: results to slots 5..8
// - Non-continuous halts after four or eight
// - Single four continuous wraps to slot 5
// - Single eight: results to slots 1..8
// - Single eight continuous wraps to slot 1
// - Multi channel converts a group of inputs
// - Multi four decodes only bits 3,2
// - Multi four single: group in slots 5..8
// - Multi four continuous cycles the group
// - Multi eight: input n to slot n+1
// - Multi eight ignores channel bits 3..0
// - Multi eight continuous wraps to slot 1
// - Complete flag after first full pass
// - Control write clears flag, aborts, restarts
// - Power enable gates converter power
// - Clock select: bus clock or RC
// - Bus clock mode samples on quiet phase
// - Stop/wait suspends, then resamples channel
// - Four conversions take 144 bus cycles (code: CONV_CYC plus one wait cycle each, at least 148)
// - Power off aborts running conversion
// - Result left aligned, low six zero
// - Result bytes: high eight, then two
`timescale 1ns/1ps
`include "acs_defs.vh"
module acs_sequencer #(
  parameter CONV_CYC = `ACS_CONV_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        low_power_mode,
  output reg  [3:0]  conv_channel,
  output reg         conv_start,
  input  wire [9:0]  conv_result,
  input  wire        conv_done,
  output wire        analog_power_enable,
  output wire        conversion_clock_select,
  output wire        sample_quiet_phase,
  output wire        stop_exit_delay_enable,
  output wire        seq_busy
);

  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_CONV = 2'b10;
  localparam ST_HALT = 2'b11;

  reg [7:0]  ctl_r;
  reg [2:0]  opt_r;
  reg [1:0]  state_r;
  reg [2:0]  step_r;
  reg        wrapped_r;
  reg [7:0]  cyc_r;
  reg [9:0]  slot_r [0:7];
  reg        done_s1_r;
  reg        done_s2_r;
  reg        done_s3_r;
  reg  [9:0] res_hold_r;

  wire       wr    = psel & penable & pwrite;
  wire       rd    = psel & penable & ~pwrite;
  wire       ctl_wr = wr & (paddr == `ACS_CTL_ADDR);
  wire       opt_wr = wr & (paddr == `ACS_OPT_ADDR);
  wire       eight_conversion_select = ctl_r[`ACS_EIGHT_CONVERSION_SELECT_BIT];
  wire       scan  = ctl_r[`ACS_SCAN_BIT];
  wire       multi_channel_select  = ctl_r[`ACS_MULTI_CHANNEL_SELECT_BIT];
  wire       pwr   = opt_r[`ACS_PU_BIT];
  wire       rcsel = opt_r[`ACS_CONVERSION_CLOCK_SELECT_BIT];
  wire [2:0] last_step = eight_conversion_select ? 3'h7 : 3'h3;
  wire [2:0] slot_idx  = eight_conversion_select ? step_r : {1'b1, step_r[1:0]};

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign analog_power_enable = pwr;
  assign conversion_clock_select = rcsel;
  assign stop_exit_delay_enable = opt_r[`ACS_DLY_BIT];
  assign seq_busy = (state_r == ST_WAIT) | (state_r == ST_CONV);
  // quiet phase: comparator sampled at slot cycle 2 on bus clock
  assign sample_quiet_phase = ~rcsel & (state_r == ST_CONV) & (cyc_r == 8'h02);

  // Channel for current step
  function [3:0] chan_of;
    input       f_multi_channel_select;
    input       f_eight_conversion_select;
    input [3:0] f_sel;
    input [2:0] f_step;
    begin
      if (!f_multi_channel_select)
        chan_of = f_sel;
      else if (f_eight_conversion_select)
        chan_of = {1'b0, f_step};
      else
        chan_of = {f_sel[3:2], f_step[1:0]};
    end
  endfunction

  // Done edge: synchronised in RC mode, direct in bus mode
  wire done_ev = rcsel ? (done_s2_r & ~done_s3_r) : conv_done;
  // Held result in RC mode; the core may drop its data before the sync edge
  wire [9:0] res_in = rcsel ? res_hold_r : conv_result;

  // two-flop sync, first flop only feeds second
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_s3_r <= 1'b0;
      res_hold_r <= 10'h000;
    end
    else
    begin
      done_s1_r <= conv_done;
      done_s2_r <= done_s1_r;
      done_s3_r <= done_s2_r;
      if (conv_done)
        res_hold_r <= conv_result;
    end
  end

  // Option register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      opt_r <= 3'h0;
    else if (opt_wr)
      opt_r <= pwdata[2:0];
  end

  // Sequencer and control/status register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_r <= `ACS_CTL_RST;
      state_r <= ST_IDLE;
      step_r <= 3'h0;
      wrapped_r <= 1'b0;
      cyc_r <= 8'h00;
      conv_start <= 1'b0;
      conv_channel <= 4'h0;
    end
    else
    begin
      conv_start <= 1'b0;
      if (ctl_wr)
      begin
        ctl_r <= {1'b0, pwdata[6:0]};
        step_r <= 3'h0;
        wrapped_r <= 1'b0;
        state_r <= ST_WAIT;
      end
      else if (!pwr && seq_busy)
        state_r <= ST_HALT;
      else
      begin
        case (state_r)
          ST_WAIT:
          begin
            // held while suspended; resample on resume
            if (!low_power_mode && pwr)
            begin
              conv_channel <= chan_of(multi_channel_select, eight_conversion_select, ctl_r[3:0], step_r);
              conv_start <= 1'b1;
              cyc_r <= 8'h00;
              state_r <= ST_CONV;
            end
          end
          ST_CONV:
          begin
            cyc_r <= cyc_r + 8'h01;
            if (low_power_mode)
              state_r <= ST_WAIT;
            // bus mode paced to fixed slot length
            else if (done_ev && (rcsel || cyc_r >= CONV_CYC[7:0] - 8'h01))
            begin
              if (step_r == last_step)
              begin
                ctl_r[`ACS_CCF_BIT] <= 1'b1;
                wrapped_r <= 1'b1;
                step_r <= 3'h0;
                state_r <= scan ? ST_WAIT : ST_HALT;
              end
              else
              begin
                step_r <= step_r + 3'h1;
                state_r <= ST_WAIT;
              end
            end
          end
          ST_HALT:
            state_r <= ST_HALT;
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // result written once per completed conversion
  always @(posedge pclk)
  begin
    if (state_r == ST_CONV && !ctl_wr && pwr && !low_power_mode && done_ev &&
        (rcsel || cyc_r >= CONV_CYC[7:0] - 8'h01))
      slot_r[slot_idx] <= res_in;
  end

  // Read mux; slots unwritten since reset read undefined, as on silicon
  wire [2:0] rd_slot = paddr[4:2];
  always @*
  begin
    prdata = 32'h0000_0000;
    if (rd && paddr == `ACS_CTL_ADDR)
      prdata = {24'h000000, ctl_r};
    else if (rd && paddr == `ACS_OPT_ADDR)
      prdata = {29'h0, opt_r};
    else if (rd && paddr >= `ACS_RES_BASE && paddr <= `ACS_RES_LAST && paddr[1:0] == 2'b00)
      // left aligned, bytes high then low
      prdata = {16'h0000, slot_r[rd_slot], 6'h00};
  end

endmodule
